// File: hdl/cbx_pkg.sv
// Package for the branch, skip and bit-operation execution core
package cbx_pkg;

	////////////////////////////////////////////////////////////////////////
	// Instruction classes, held in bits 15:12 of the instruction word
	typedef enum logic [3:0] {
		OP_REG1    = 4'h0,
		OP_REG2    = 4'h1,
		OP_CMP_IMM = 4'h3,
		OP_PC_RELATIVE_JUMP    = 4'h4,
		OP_PC_RELATIVE_CALL   = 4'h5,
		OP_BRANCH  = 4'h6,
		OP_SKIPREG = 4'h7,
		OP_IOBIT   = 4'h8,
		OP_MISC    = 4'h9,
		OP_LONG    = 4'hf
	} cbx_op_t;

	// Single-register operations, bits 11:8
	localparam logic [3:0] SUB_TEST_ZERO_OR_SIGN = 4'h0;
	localparam logic [3:0] SUB_ZERO_REGISTER_OP  = 4'h1;
	localparam logic [3:0] SUB_FILL_ONES_OP      = 4'h2;
	localparam logic [3:0] SUB_INCREMENT         = 4'h3;
	localparam logic [3:0] SUB_DECREMENT         = 4'h4;
	localparam logic [3:0] SUB_ROTATE_LEFT_CARRY = 4'h5;
	// Two-register operations, bits 11:10
	localparam logic [1:0] SUB_REGISTER_COMPARE  = 2'h0;
	localparam logic [1:0] SUB_COMPARE_CARRY_IN  = 2'h1;
	localparam logic [1:0] SUB_COMPARE_SKIP_EQ   = 2'h2;
	// I/O bit operations, bits 11:10
	localparam logic [1:0] SUB_IO_BIT_FORCE_ONE  = 2'h0;
	localparam logic [1:0] SUB_IO_BIT_FORCE_ZERO = 2'h1;
	localparam logic [1:0] SUB_SKIP_IO_BIT_CLEAR = 2'h2;
	localparam logic [1:0] SUB_SKIP_IO_BIT_SET   = 2'h3;
	// Indirect and return operations, bits 3:0
	localparam logic [3:0] SUB_PTR_INDIRECT_JUMP = 4'h0;
	localparam logic [3:0] SUB_PTR_INDIRECT_CALL = 4'h1;
	localparam logic [3:0] SUB_SUBROUTINE_EXIT   = 4'h2;
	localparam logic [3:0] SUB_INTERRUPT_EXIT    = 4'h3;

	////////////////////////////////////////////////////////////////////////
	// Flag positions in the status flags register
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	// Register pair that forms the 16-bit pointer, and base of immediates
	localparam logic [4:0] PTR_LO_REG   = 5'h1e;
	localparam logic [4:0] PTR_HI_REG   = 5'h1f;
	localparam logic       IMM_REG_BASE = 1'h1;

	////////////////////////////////////////////////////////////////////////
	// Cycle counts; the wait count is what remains after the first two cycles
	localparam int CYC_JUMP   = 2;
	localparam int CYC_CALL   = 3;
	localparam int CYC_RETURN = 4;
	localparam int CYC_BR_HIT = 2;
	localparam logic [1:0] WAIT_JUMP   = 2'(CYC_JUMP - 2);
	localparam logic [1:0] WAIT_CALL   = 2'(CYC_CALL - 2);
	localparam logic [1:0] WAIT_RETURN = 2'(CYC_RETURN - 2);
	localparam logic [1:0] WAIT_BR_HIT = 2'(CYC_BR_HIT - 2);
	localparam logic [1:0] WAIT_LONG   = 2'h0;

	localparam int STK_DEPTH = 16;
	localparam int STK_AW    = 4;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_WAIT = 2'b01,
		ST_SKIP = 2'b10,
		ST_IOWR = 2'b11
	} cbx_st_t;

	typedef struct packed {
		cbx_st_t                        st;
		logic [1:0]                     cnt;
		logic [15:0]                    pc;
		logic [STK_AW-1:0]              sp;
		logic [7:0]                     flags;
		logic [31:0][7:0]               rf;
		logic [STK_DEPTH-1:0][15:0]     stk;
		logic [4:0]                     io_addr;
		logic [7:0]                     io_data;
		logic [7:0]                     rf_rdata;
	} cbx_state_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} cbx_io_req_t;

	localparam cbx_state_t CBX_STATE_RST = '0;

endpackage

// File: hdl/cbx_core.sv
// Execution core for compare, skip, branch, jump, return and I/O bit ops
`timescale 1ns/1ns
module cbx_core
	import cbx_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic [15:0] i_instr,
	output logic      [15:0] o_pc,
	input  wire logic [7:0]  i_io_rdata,
	output cbx_io_req_t      o_io,
	input  wire logic        i_rf_we,
	input  wire logic [4:0]  i_rf_addr,
	input  wire logic [7:0]  i_rf_wdata,
	input  wire logic        i_flags_we,
	input  wire logic [7:0]  i_flags_wdata,
	output logic      [7:0]  o_rf_rdata,
	output logic      [7:0]  o_flags,
	output logic      [3:0]  o_sp,
	output logic             o_busy
);

	////////////////////////////////////////////////////////////////////////
	// Instruction fields
	cbx_state_t  r;
	cbx_state_t  n;
	cbx_op_t     op;
	logic        exe;
	logic [4:0]  f_d;
	logic [4:0]  f_r;
	logic [4:0]  f_io;
	logic [2:0]  f_bit;
	logic [15:0] ptr_z;
	logic [15:0] pc_inc;
	logic [15:0] k_rel;
	logic [15:0] k_br;
	logic        br_flag;
	logic        br_taken;

	assign op     = cbx_op_t'(i_instr[15:12]);
	assign exe    = (r.st == ST_EXEC) && i_ce;
	assign f_d    = (op == OP_REG1) ? i_instr[4:0] : i_instr[9:5];
	assign f_r    = i_instr[4:0];
	assign f_io   = i_instr[7:3];
	assign f_bit  = (op == OP_SKIPREG) ? i_instr[10:8] : i_instr[2:0];
	assign ptr_z  = {r.rf[PTR_HI_REG], r.rf[PTR_LO_REG]};
	assign pc_inc = r.pc + 16'h0001;
	assign k_rel  = {{4{i_instr[11]}}, i_instr[11:0]};
	assign k_br   = {{8{i_instr[7]}}, i_instr[7:0]};

	// Signed form evaluates N xor V directly, not the stored S copy
	assign br_flag  = (i_instr[10:8] == 3'(FLG_S)) ?
		(r.flags[FLG_N] ^ r.flags[FLG_V]) : r.flags[i_instr[10:8]];
	// Carry, H, T, V and I branches are this selector with their position
	assign br_taken = br_flag ^ i_instr[11];

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [7:0] rd;
		logic [7:0] rr;
		logic [7:0] res;
		logic [8:0] dif;
		logic       skip;
		rd   = r.rf[f_d];
		rr   = r.rf[f_r];
		res  = 8'h00;
		dif  = 9'h000;
		skip = 1'b0;
		n    = r;
		case (r.st)
			ST_EXEC: begin
				n.pc = pc_inc;
				case (op)
					OP_REG1: begin
						res = rd;
						case (i_instr[11:8])
							SUB_TEST_ZERO_OR_SIGN: begin
								res = rd & rd;
								n.flags[FLG_V] = 1'b0;
							end
							SUB_ZERO_REGISTER_OP: begin
								res = rd ^ rd;
								n.flags[FLG_V] = 1'b0;
							end
							SUB_FILL_ONES_OP: res = 8'hff;
							SUB_INCREMENT: begin
								res = rd + 8'h01;
								n.flags[FLG_V] = (rd == 8'h7f);
							end
							SUB_DECREMENT: begin
								res = rd - 8'h01;
								n.flags[FLG_V] = (rd == 8'h80);
							end
							SUB_ROTATE_LEFT_CARRY: begin
								res = {rd[6:0], r.flags[FLG_C]};
								n.flags[FLG_C] = rd[7];
								n.flags[FLG_V] = res[7] ^ rd[7];
							end
							default: res = rd;
						endcase
						// Fill-ones leaves every flag alone
						if (i_instr[11:8] != SUB_FILL_ONES_OP &&
							i_instr[11:8] <= SUB_ROTATE_LEFT_CARRY) begin
							n.flags[FLG_Z] = (res == 8'h00);
							n.flags[FLG_N] = res[7];
							n.flags[FLG_S] = res[7] ^ n.flags[FLG_V];
						end
						// Test writes nothing back, so the register holds
						if (i_instr[11:8] != SUB_TEST_ZERO_OR_SIGN) begin
							n.rf[f_d] = res;
						end
					end
					OP_REG2, OP_CMP_IMM: begin
						if (op == OP_CMP_IMM) begin
							rd = r.rf[{IMM_REG_BASE, i_instr[11:8]}];
							rr = i_instr[7:0];
						end
						if (op == OP_REG2 &&
							i_instr[11:10] == SUB_COMPARE_SKIP_EQ) begin
							if (rd == rr) begin
								n.st = ST_SKIP;
							end
						end else if (op == OP_CMP_IMM ||
							i_instr[11:10] != 2'h3) begin
							// Difference is only used for flags
							dif = {1'b0, rd} - {1'b0, rr} - 9'(
								op == OP_REG2 &&
								i_instr[11:10] == SUB_COMPARE_CARRY_IN &&
								r.flags[FLG_C]);
							res = dif[7:0];
							n.flags[FLG_C] = dif[8];
							n.flags[FLG_Z] = (res == 8'h00);
							n.flags[FLG_N] = res[7];
							n.flags[FLG_V] = (rd[7] & ~rr[7] & ~res[7]) |
								(~rd[7] & rr[7] & res[7]);
							n.flags[FLG_S] = res[7] ^ n.flags[FLG_V];
							n.flags[FLG_H] = (~rd[3] & rr[3]) |
								(rr[3] & res[3]) | (res[3] & ~rd[3]);
						end
					end
					OP_PC_RELATIVE_JUMP, OP_PC_RELATIVE_CALL: begin
						n.pc  = pc_inc + k_rel;
						n.st  = ST_WAIT;
						n.cnt = WAIT_JUMP;
						if (op == OP_PC_RELATIVE_CALL) begin
							n.stk[r.sp] = pc_inc;
							n.sp        = r.sp + 4'h1;
							n.cnt       = WAIT_CALL;
						end
					end
					OP_BRANCH: begin
						// No flag is written on any branch path
						if (br_taken) begin
							n.pc  = pc_inc + k_br;
							n.st  = ST_WAIT;
							n.cnt = WAIT_BR_HIT;
						end
					end
					OP_SKIPREG: begin
						skip = (rr[f_bit] == i_instr[11]);
						if (skip) begin
							n.st = ST_SKIP;
						end
					end
					OP_IOBIT: begin
						if (i_instr[11]) begin
							skip = (i_io_rdata[f_bit] == i_instr[10]);
							if (skip) begin
								n.st = ST_SKIP;
							end
						end else begin
							// Only the addressed bit moves; the rest is read back
							n.io_addr = f_io;
							n.io_data = i_instr[10] ?
								(i_io_rdata & ~(8'h01 << f_bit)) :
								(i_io_rdata | (8'h01 << f_bit));
							n.st = ST_IOWR;
						end
					end
					OP_MISC: begin
						case (i_instr[3:0])
							SUB_PTR_INDIRECT_JUMP: begin
								n.pc  = ptr_z;
								n.st  = ST_WAIT;
								n.cnt = WAIT_JUMP;
							end
							SUB_PTR_INDIRECT_CALL: begin
								n.stk[r.sp] = pc_inc;
								n.sp        = r.sp + 4'h1;
								n.pc        = ptr_z;
								n.st        = ST_WAIT;
								n.cnt       = WAIT_CALL;
							end
							SUB_SUBROUTINE_EXIT, SUB_INTERRUPT_EXIT: begin
								n.sp  = r.sp - 4'h1;
								n.pc  = r.stk[r.sp - 4'h1];
								n.st  = ST_WAIT;
								n.cnt = WAIT_RETURN;
								if (i_instr[3:0] == SUB_INTERRUPT_EXIT) begin
									n.flags[FLG_I] = 1'b1;
								end
							end
							default: n.pc = pc_inc;
						endcase
					end
					OP_LONG: begin
						// Two-word filler; steps over its second word
						n.pc  = r.pc + 16'h0002;
						n.st  = ST_WAIT;
						n.cnt = WAIT_LONG;
					end
					default: n.pc = pc_inc;
				endcase
			end
			ST_SKIP: begin
				// The word now fetched is the one being skipped
				if (cbx_op_t'(i_instr[15:12]) == OP_LONG) begin
					n.pc  = r.pc + 16'h0002;
					n.st  = ST_WAIT;
					n.cnt = WAIT_LONG;
				end else begin
					n.pc = pc_inc;
					n.st = ST_EXEC;
				end
			end
			ST_WAIT: begin
				if (r.cnt == 2'h0) begin
					n.st = ST_EXEC;
				end else begin
					n.cnt = r.cnt - 2'h1;
				end
			end
			default: n.st = ST_EXEC;
		endcase
		// Side loads win over the instruction in the same cycle
		if (i_flags_we) begin
			n.flags = i_flags_wdata;
		end
		if (i_rf_we) begin
			n.rf[i_rf_addr] = i_rf_wdata;
		end
		n.rf_rdata = n.rf[i_rf_addr];
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= CBX_STATE_RST;
		end else if (i_ce) begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; strobes are gated so a frozen cycle has no side effect
	assign o_io = '{
		addr:  (r.st == ST_IOWR) ? r.io_addr : f_io,
		wdata: r.io_data,
		we:    (r.st == ST_IOWR) && i_ce,
		re:    exe && (op == OP_IOBIT)
	};
	assign o_pc       = r.pc;
	assign o_rf_rdata = r.rf_rdata;
	assign o_flags    = r.flags;
	assign o_sp       = r.sp;
	assign o_busy     = (r.st != ST_EXEC);

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic is_tst;
	logic is_cmp;
	logic is_misc;
	assign is_tst  = exe && op == OP_REG1 &&
		i_instr[11:8] == SUB_TEST_ZERO_OR_SIGN && !i_rf_we && !i_flags_we;
	assign is_cmp  = exe && op == OP_REG2 &&
		i_instr[11:10] == SUB_REGISTER_COMPARE && !i_rf_we && !i_flags_we;
	assign is_misc = exe && op == OP_MISC;

	test_keeps_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_tst |=> r.rf[$past(f_d)] == $past(rd_probe) &&
			r.flags[FLG_Z] == ($past(rd_probe) == 8'h00))
		else $error("test changed register or wrong zero flag");

	logic [7:0] rd_probe;
	assign rd_probe = r.rf[f_d];

	pointer_indirect_jump_target_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_misc && i_instr[3:0] == SUB_PTR_INDIRECT_JUMP && !i_rf_we
		|=> o_pc == $past(ptr_z) && o_busy)
		else $error("indirect jump target wrong");

	pointer_indirect_call_push_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_misc && i_instr[3:0] == SUB_PTR_INDIRECT_CALL
		|=> r.stk[r.sp - 4'h1] == $past(pc_inc) && r.cnt == 2'h1)
		else $error("indirect call push wrong");

	cmp_nostore_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_cmp |=> r.rf == $past(r.rf) &&
			r.flags[FLG_C] == ($past(rd_probe) < $past(r.rf[f_r])))
		else $error("compare stored result or wrong carry");

	br_taken_a: assert property (@(posedge i_clk) disable iff (i_rst)
		exe && op == OP_BRANCH && !i_flags_we
		|=> o_pc == ($past(br_taken) ? $past(pc_inc + k_br) : $past(pc_inc))
			&& o_flags == $past(o_flags) && o_busy == $past(br_taken))
		else $error("branch target, timing or flags wrong");

	skip_eq_a: assert property (@(posedge i_clk) disable iff (i_rst)
		exe && op == OP_REG2 && i_instr[11:10] == SUB_COMPARE_SKIP_EQ &&
		rd_probe == r.rf[f_r] |=> r.st == ST_SKIP)
		else $error("compare skip did not enter skip");

	io_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
		exe && op == OP_IOBIT && i_instr[11:10] == SUB_IO_BIT_FORCE_ONE
		##1 i_ce |-> o_io.we && o_io.wdata[$past(f_bit)] &&
			o_io.addr == $past(f_io))
		else $error("io bit set write wrong");

	io_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
		exe && op == OP_IOBIT && i_instr[11:10] == SUB_IO_BIT_FORCE_ZERO
		|=> o_io.wdata == ($past(i_io_rdata) & ~(8'h01 << $past(f_bit))))
		else $error("io bit clear data wrong");

	rol_carry_a: assert property (@(posedge i_clk) disable iff (i_rst)
		exe && op == OP_REG1 && i_instr[11:8] == SUB_ROTATE_LEFT_CARRY &&
		!i_rf_we && !i_flags_we
		|=> r.rf[$past(f_d)] == {$past(rd_probe[6:0]), $past(o_flags[FLG_C])}
			&& o_flags[FLG_C] == $past(rd_probe[7]))
		else $error("rotate left result or carry wrong");

	interrupt_exit_ie_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_misc && i_instr[3:0] == SUB_INTERRUPT_EXIT && !i_flags_we
		|=> o_flags[FLG_I] && r.cnt == 2'h2 && o_pc == $past(r.stk[r.sp-4'h1]))
		else $error("interrupt return wrong");

endmodule // cbx_core

// File: tb/cbx_mem_model.sv
// Program memory and I/O register space facing the execution core
`timescale 1ns/1ns
module cbx_mem_model
	import cbx_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic [15:0] i_pc,
	output logic      [15:0] o_instr,
	input  cbx_io_req_t      i_io,
	output logic      [7:0]  o_io_rdata
);
	logic [15:0] rom [256];
	logic [7:0]  io  [32];

	////////////////////////////////////////////////////////////////////////
	// Async read, so the core sees the word in the cycle it asks for it
	assign o_instr    = rom[i_pc[7:0]];
	assign o_io_rdata = io[i_io.addr];

	// Write strobe is already gated by the core's clock enable
	always @(posedge i_clk) begin
		if (i_io.we) begin
			io[i_io.addr] <= i_io.wdata;
		end
	end

	// Unwritten words decode as one-cycle no-ops
	initial begin
		foreach (rom[i]) rom[i] = 16'h2000;
		foreach (io[i]) io[i] = 8'h00;
	end
endmodule // cbx_mem_model

// File: tb/test_cpu_branch_skip_bitop_exec.sv
// Self-checking bench for the branch, skip and bit-operation core
`timescale 1ns/1ns
module test_cpu_branch_skip_bitop_exec;
	import cbx_pkg::*;
	logic        i_clk         = 1'b0;
	logic        i_rst         = 1'b1;
	logic        i_ce          = 1'b1;
	logic        i_rf_we       = 1'b0;
	logic [4:0]  i_rf_addr     = 5'h00;
	logic [7:0]  i_rf_wdata    = 8'h00;
	logic        i_flags_we    = 1'b0;
	logic [7:0]  i_flags_wdata = 8'h00;
	logic [15:0] i_instr;
	logic [15:0] o_pc;
	logic [7:0]  i_io_rdata;
	cbx_io_req_t o_io;
	logic [7:0]  o_rf_rdata;
	logic [7:0]  o_flags;
	logic [3:0]  o_sp;
	logic        o_busy;
	logic [15:0] pcx = 16'h0000;
	int          fail_count = 0;
	int          n_tests = 0;

	cbx_core uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
		.i_instr(i_instr), .o_pc(o_pc), .i_io_rdata(i_io_rdata),
		.o_io(o_io), .i_rf_we(i_rf_we), .i_rf_addr(i_rf_addr),
		.i_rf_wdata(i_rf_wdata), .i_flags_we(i_flags_we),
		.i_flags_wdata(i_flags_wdata), .o_rf_rdata(o_rf_rdata),
		.o_flags(o_flags), .o_sp(o_sp), .o_busy(o_busy));
	cbx_mem_model mem (.i_clk(i_clk), .i_pc(o_pc), .o_instr(i_instr),
		.i_io(o_io), .o_io_rdata(i_io_rdata));

	always #20 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic tick();
		@(posedge i_clk);
		#1;
	endtask

	// Side loads ride on a no-op, so the program counter still steps
	task automatic ld(input logic [4:0] a, input logic [7:0] d);
		mem.rom[pcx[7:0]] = 16'h2000;
		i_rf_addr = a;
		i_rf_wdata = d;
		i_rf_we = 1'b1;
		tick();
		i_rf_we = 1'b0;
		pcx++;
	endtask

	task automatic fl(input logic [7:0] d);
		mem.rom[pcx[7:0]] = 16'h2000;
		i_flags_wdata = d;
		i_flags_we = 1'b1;
		tick();
		i_flags_we = 1'b0;
		pcx++;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		mem.rom[pcx[7:0]] = 16'h2000;
		mem.rom[8'(pcx + 16'h1)] = 16'h2000;
		i_rf_addr = a;
		tick();
		tick();
		pcx = pcx + 16'h2;
		chk({8'h00, o_rf_rdata}, {8'h00, e});
	endtask

	// One instruction, then its cycle count and landing address
	task automatic run(input logic [15:0] w, nxt, input int cyc,
		input logic [15:0] pce);
		int n;
		mem.rom[pcx[7:0]] = w;
		mem.rom[8'(pcx + 16'h1)] = nxt;
		tick();
		n = 1;
		while (o_busy !== 1'b0 && n < 8) begin
			tick();
			n++;
		end
		chk(16'(n), 16'(cyc));
		chk(o_pc, pce);
		pcx = pce;
		if (n >= 8) begin
			give_verdict();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic reg1(input logic [3:0] s, input logic [7:0] v0, pf, v1,
		input logic [3:0] lf);
		ld(5'h03, v0);
		fl(pf);
		run({4'h0, s, 8'h03}, 16'h2000, 1, pcx + 16'h1);
		chk({12'h000, o_flags[3:0]}, {12'h000, lf});
		rd(5'h03, v1);
	endtask

	task automatic cmp1(input logic [15:0] w, input logic [4:0] ra, rb,
		input logic [7:0] a, b, pf, ef);
		ld(ra, a);
		ld(rb, b);
		fl(pf);
		run(w, 16'h2000, 1, pcx + 16'h1);
		chk({8'h00, o_flags & 8'h2f}, {8'h00, ef});
		rd(ra, a);
	endtask

	// Every flag position, both forms, flag up and down
	task automatic t_branch();
		logic [7:0] f;
		for (int s = 0; s < 8; s++) begin
			for (int c = 0; c < 2; c++) begin
				for (int v = 0; v < 2; v++) begin
					f = (s == 4) ? 8'h04 : (8'h01 << s);
					f = (v == 1) ? f : 8'h00;
					fl(f);
					if ((v ^ c) == 1) begin
						run({4'h6, c[0], 3'(s), 8'hfd}, 16'h2000, 2, pcx - 16'h2);
					end else begin
						run({4'h6, c[0], 3'(s), 8'hfd}, 16'h2000, 1, pcx + 16'h1);
					end
					chk({8'h00, o_flags}, {8'h00, f});
				end
			end
		end
	endtask

	task automatic t_jumps();
		ld(5'h1e, 8'h40);
		ld(5'h1f, 8'h00);
		fl(8'h5a);
		run(16'h9000, 16'h2000, 2, 16'h0040);
		chk({8'h00, o_flags}, 16'h005a);
		ld(5'h1e, 8'h80);
		run(16'h9001, 16'h2000, 3, 16'h0080);
		chk({12'h000, o_sp}, 16'h0001);
		run(16'h5005, 16'h2000, 3, 16'h0086);
		chk({12'h000, o_sp}, 16'h0002);
		run(16'h9002, 16'h2000, 4, 16'h0081);
		run(16'h9003, 16'h2000, 4, 16'h0042);
		chk({4'h0, o_sp, o_flags}, 16'h00da);
		// Clock enable low must freeze the core completely
		i_ce = 1'b0;
		tick();
		tick();
		chk(o_pc, pcx);
		i_ce = 1'b1;
		run(16'h4ffe, 16'h2000, 2, pcx - 16'h1);
	endtask

	task automatic t_skip();
		ld(5'h06, 8'h5a);
		ld(5'h07, 8'h5a);
		mem.io[3] = 8'h04;
		run(16'h18c7, 16'h2000, 2, pcx + 16'h2);
		run(16'h18c7, 16'hf000, 3, pcx + 16'h3);
		ld(5'h07, 8'h5b);
		run(16'h18c7, 16'hf000, 1, pcx + 16'h1);
		run(16'h7006, 16'h2000, 2, pcx + 16'h2);
		run(16'h7806, 16'hf000, 1, pcx + 16'h1);
		run(16'h7906, 16'hf000, 3, pcx + 16'h3);
		run(16'h881a, 16'h2000, 1, pcx + 16'h1);
		run(16'h8819, 16'h2000, 2, pcx + 16'h2);
		run(16'h8c1a, 16'hf000, 3, pcx + 16'h3);
	endtask

	task automatic t_iobit();
		mem.io[5] = 8'ha5;
		mem.io[4] = 8'h3c;
		fl(8'h00);
		run(16'h8029, 16'h2000, 2, pcx + 16'h1);
		chk({o_flags, mem.io[5]}, 16'h00a7);
		run(16'h8428, 16'h2000, 2, pcx + 16'h1);
		chk({mem.io[4], mem.io[5]}, 16'h3ca6);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		reg1(4'h0, 8'h80, 8'h00, 8'h80, 4'h4);
		reg1(4'h1, 8'h5a, 8'h00, 8'h00, 4'h2);
		reg1(4'h2, 8'h5a, 8'h0d, 8'hff, 4'hd);
		reg1(4'h3, 8'h7f, 8'h00, 8'h80, 4'hc);
		reg1(4'h4, 8'h80, 8'h00, 8'h7f, 4'h8);
		reg1(4'h5, 8'h81, 8'h01, 8'h03, 4'h9);
		cmp1(16'h1085, 5'h04, 5'h05, 8'h10, 8'h20, 8'h00, 8'h05);
		cmp1(16'h1485, 5'h04, 5'h05, 8'h20, 8'h1f, 8'h01, 8'h22);
		cmp1(16'h3005, 5'h10, 5'h10, 8'h05, 8'h05, 8'h00, 8'h02);
		t_branch();
		t_jumps();
		t_skip();
		t_iobit();
		give_verdict();
	end
endmodule // test_cpu_branch_skip_bitop_exec
